// File: core/crcap_defs.vh
`ifndef CRCAP_DEFS_VH
`define CRCAP_DEFS_VH
// Register indices; byte address is four times the index
`define CRCAP_IDX_CTRL     6'h16
`define CRCAP_IDX_WIN      6'h17
`define CRCAP_IDX_PEAK     6'h18
`define CRCAP_IDX_THR      6'h19
// Control field positions
`define CRCAP_CTRL_ENABLE  15
`define CRCAP_CTRL_FAST    14
`define CRCAP_CTRL_LPAIR   13
`define CRCAP_CTRL_MPAIR   12
`define CRCAP_CTRL_LAUNCH  11
`define CRCAP_CTRL_WID_HI  10
`define CRCAP_CTRL_WID_LO  8
`define CRCAP_CTRL_POL     7
`define CRCAP_CTRL_THR_HI  5
`define CRCAP_CTRL_THR_LO  0
// Window field positions
`define CRCAP_WIN_START_HI 15
`define CRCAP_WIN_START_LO 8
`define CRCAP_WIN_STOP_HI  7
`define CRCAP_WIN_STOP_LO  0
// Reset values, sample midpoint and last time count
`define CRCAP_CTRL_RST     16'h0020
`define CRCAP_WIN_RST      16'h0000
`define CRCAP_SMP_MID      6'h20
`define CRCAP_TIME_LAST    8'hff
// Timing
`define CRCAP_CLK_NS       10
`define CRCAP_SMP_NS       8
`define CRCAP_LP_UNIT_NS   50
`define CRCAP_SMP_CYC      ((`CRCAP_SMP_NS + `CRCAP_CLK_NS - 1) / `CRCAP_CLK_NS)
`define CRCAP_LP_CYC       ((`CRCAP_LP_UNIT_NS + `CRCAP_CLK_NS - 1) / `CRCAP_CLK_NS)
`endif

// File: core/crcap_top.v
// Contract
// - Enable bit forces diagnostic power-up state
// - Fast mode: 8 ns units, alternating polarity (code uses one 10 ns clock cycle per unit)
// - Slow mode: 50 ns or 100 ns link pulse
// - Launch pair select: transmit or receive
// - Monitor pair select: transmit or receive
// - Launch bit sends pulse, self-clears after capture
// - Three-bit width field sets pulse length
// - Zero width sends nothing, capture still runs
// - Polarity bit picks maximum or minimum peak
// - Threshold compared above or below per mode
// - Samples span 0x00..0x3f, midpoint 0x20
// - Window times counted in 8 ns samples (code counts 10 ns clock cycles)
// - Window register holds start and stop
// - Peak value reported within window
// - Peak time is first occurrence only
// - Peak reserved bits read zero, ignore writes
// - Threshold-met flag set when condition seen
// - Threshold hit time of first qualifying sample
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "crcap_defs.vh"

module crcap_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [5:0]  rx_sample,
  output wire        diag_mode_force,
  output wire        fast_pulse_pos,
  output wire        fast_pulse_neg,
  output wire        link_pulse_drive,
  output wire        link_pulse_full,
  output wire        launch_on_rx_pair,
  output wire        monitor_rx_pair
);

  // ********************************
  // Constants and state codes
  // ********************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN  = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;
  localparam [3:0] SMP_LAST = `CRCAP_SMP_CYC - 1;
  localparam [7:0] SMP_CYC8 = `CRCAP_SMP_CYC;
  localparam [7:0] LP_CYC8  = `CRCAP_LP_CYC;

  // Sample beats the reference in the active direction
  function beats;
    input [5:0] smp;
    input [5:0] ref_val;
    input       min_mode;
    begin
      beats = min_mode ? (smp < ref_val) : (smp > ref_val);
    end
  endfunction

  // ********************************
  // Registers
  // ********************************
  reg [15:0] ctrl_ff;
  reg [15:0] nxt_ctrl;
  reg [15:0] win_ff;
  reg [15:0] nxt_win;
  reg [2:0]  state_ff;
  reg [2:0]  nxt_state;
  reg [3:0]  div_ff;
  reg [7:0]  time_ff;
  reg [7:0]  nxt_time;
  reg [7:0]  pulse_left_ff;
  reg [7:0]  nxt_pulse_left;
  reg        neg_next_ff;
  reg        nxt_neg_next;
  reg [5:0]  peak_value_ff;
  reg [5:0]  nxt_peak_value;
  reg [7:0]  peak_time_ff;
  reg [7:0]  nxt_peak_time;
  reg        peak_seen_ff;
  reg        nxt_peak_seen;
  reg        threshold_met_flag_ff;
  reg        nxt_threshold_met_flag;
  reg [7:0]  threshold_hit_time_ff;
  reg [7:0]  nxt_threshold_hit_time;
  reg [5:0]  smp_meta_ff;
  reg [5:0]  smp_sync_ff;
  reg [31:0] prdata_ff;
  reg [31:0] nxt_prdata;
  reg        pready_ff;
  reg        pslverr_ff;
  reg        nxt_pslverr;
  reg        fast_pos_ff;
  reg        fast_neg_ff;
  reg        lp_drive_ff;
  reg        lp_full_ff;
  reg        lpair_ff;
  reg        mpair_ff;
  reg        diag_ff;

  wire [5:0] acc_idx  = paddr[7:2];
  wire       acc_ok   = psel & penable & ~pready_ff;
  wire       wr_now   = acc_ok & pwrite;
  wire       smp_tick = (div_ff == SMP_LAST);
  wire       fast_on  = (nxt_pulse_left != 8'h00) & nxt_ctrl[`CRCAP_CTRL_FAST];
  wire       min_mode = ctrl_ff[`CRCAP_CTRL_POL];
  wire [5:0] thr      = ctrl_ff[`CRCAP_CTRL_THR_HI:`CRCAP_CTRL_THR_LO];
  wire [7:0] w_start  = win_ff[`CRCAP_WIN_START_HI:`CRCAP_WIN_START_LO];
  wire [7:0] w_stop   = win_ff[`CRCAP_WIN_STOP_HI:`CRCAP_WIN_STOP_LO];
  wire       in_win   = (time_ff >= w_start) && (time_ff <= w_stop);
  wire       evaluate = state_ff[1] & smp_tick & in_win;
  wire       launch_req = wr_now && (acc_idx == `CRCAP_IDX_CTRL) &&
                          pwdata[`CRCAP_CTRL_LAUNCH] && state_ff[0];
  wire       run_end  = smp_tick && ((time_ff == w_stop) || (time_ff == `CRCAP_TIME_LAST));

  // ********************************
  // Sample input synchroniser
  // ********************************
  // Front-end samples are on another clock; two flops before any use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_meta_ff <= 6'h00;
      smp_sync_ff <= 6'h00;
    end else begin
      smp_meta_ff <= rx_sample;
      smp_sync_ff <= smp_meta_ff;
    end
  end

  // ********************************
  // Sample tick divider
  // ********************************
  // Rounded up to whole cycles, so samples are never faster than 8 ns
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 4'h0;
    end else if (smp_tick || state_ff[0]) begin
      div_ff <= 4'h0;
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end

  // ********************************
  // Register writes
  // ********************************
  // Launch bit is self-clearing; writing zero cannot abort a run
  always @* begin
    nxt_ctrl = ctrl_ff;
    nxt_win  = win_ff;
    if (wr_now && (acc_idx == `CRCAP_IDX_CTRL)) begin
      nxt_ctrl = pwdata[15:0];
      nxt_ctrl[`CRCAP_CTRL_LAUNCH] = ctrl_ff[`CRCAP_CTRL_LAUNCH] | launch_req;
    end
    if (wr_now && (acc_idx == `CRCAP_IDX_WIN)) begin
      nxt_win = pwdata[15:0];
    end
    if (state_ff[2]) begin
      nxt_ctrl[`CRCAP_CTRL_LAUNCH] = 1'b0;
    end
  end

  // ********************************
  // Sequencer
  // ********************************
  // Pulse counts down in every state, so a short window never strands it
  always @* begin
    nxt_state      = state_ff;
    nxt_time       = time_ff;
    nxt_pulse_left = pulse_left_ff - {7'h00, (pulse_left_ff != 8'h00)};
    nxt_neg_next   = neg_next_ff;
    case (state_ff)
      ST_IDLE: begin
        if (launch_req) begin
          nxt_state = ST_RUN;
          nxt_time  = 8'h00;
          if (pwdata[`CRCAP_CTRL_WID_HI:`CRCAP_CTRL_WID_LO] == 3'd0) begin
            nxt_pulse_left = 8'h00;
          end else if (pwdata[`CRCAP_CTRL_FAST]) begin
            nxt_pulse_left = SMP_CYC8 * {5'h00, pwdata[10:8]};
            nxt_neg_next   = ~neg_next_ff;
          end else if (pwdata[`CRCAP_CTRL_WID_HI:`CRCAP_CTRL_WID_LO] == 3'd1) begin
            nxt_pulse_left = LP_CYC8;
          end else begin
            nxt_pulse_left = LP_CYC8 + LP_CYC8;
          end
        end
      end
      ST_RUN: begin
        if (smp_tick) begin
          nxt_time = time_ff + 8'h01;
        end
        if (run_end) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ********************************
  // Peak and threshold capture
  // ********************************
  // First in-window sample seeds the peak; ties keep the earlier time
  always @* begin
    nxt_peak_value         = peak_value_ff;
    nxt_peak_time          = peak_time_ff;
    nxt_peak_seen          = peak_seen_ff;
    nxt_threshold_met_flag = threshold_met_flag_ff;
    nxt_threshold_hit_time = threshold_hit_time_ff;
    if (launch_req) begin
      nxt_peak_value         = 6'h00;
      nxt_peak_time          = 8'h00;
      nxt_peak_seen          = 1'b0;
      nxt_threshold_met_flag = 1'b0;
      nxt_threshold_hit_time = 8'h00;
    end else if (evaluate) begin
      if (!peak_seen_ff || beats(smp_sync_ff, peak_value_ff, min_mode)) begin
        nxt_peak_value = smp_sync_ff;
        nxt_peak_time  = time_ff;
        nxt_peak_seen  = 1'b1;
      end
      if (!threshold_met_flag_ff && beats(smp_sync_ff, thr, min_mode)) begin
        nxt_threshold_met_flag = 1'b1;
        nxt_threshold_hit_time = time_ff;
      end
    end
  end

  // ********************************
  // APB read mux and response
  // ********************************
  // Unmapped indices answer with an error and zero data
  always @* begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    case (acc_idx)
      `CRCAP_IDX_CTRL: nxt_prdata = {16'h0000, ctrl_ff};
      `CRCAP_IDX_WIN:  nxt_prdata = {16'h0000, win_ff};
      `CRCAP_IDX_PEAK: nxt_prdata = {18'h00000, peak_value_ff, peak_time_ff};
      `CRCAP_IDX_THR:  nxt_prdata = {23'h000000, threshold_met_flag_ff,
                                     threshold_hit_time_ff};
      default:         nxt_pslverr = 1'b1;
    endcase
  end

  // ********************************
  // State flops
  // ********************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff               <= `CRCAP_CTRL_RST;
      win_ff                <= `CRCAP_WIN_RST;
      state_ff              <= ST_IDLE;
      time_ff               <= 8'h00;
      pulse_left_ff         <= 8'h00;
      neg_next_ff           <= 1'b0;
      peak_value_ff         <= 6'h00;
      peak_time_ff          <= 8'h00;
      peak_seen_ff          <= 1'b0;
      threshold_met_flag_ff <= 1'b0;
      threshold_hit_time_ff <= 8'h00;
      prdata_ff             <= 32'h0000_0000;
      pready_ff             <= 1'b0;
      pslverr_ff            <= 1'b0;
    end else begin
      ctrl_ff               <= nxt_ctrl;
      win_ff                <= nxt_win;
      state_ff              <= nxt_state;
      time_ff               <= nxt_time;
      pulse_left_ff         <= nxt_pulse_left;
      neg_next_ff           <= nxt_neg_next;
      peak_value_ff         <= nxt_peak_value;
      peak_time_ff          <= nxt_peak_time;
      peak_seen_ff          <= nxt_peak_seen;
      threshold_met_flag_ff <= nxt_threshold_met_flag;
      threshold_hit_time_ff <= nxt_threshold_hit_time;
      pready_ff             <= acc_ok; // one wait state per access
      if (acc_ok) begin
        prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
        pslverr_ff <= nxt_pslverr;
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // ********************************
  // Line drive outputs
  // ********************************
  // Registered so the analog side never sees decode glitches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_pos_ff <= 1'b0;
      fast_neg_ff <= 1'b0;
      lp_drive_ff <= 1'b0;
      lp_full_ff  <= 1'b0;
      lpair_ff    <= 1'b0;
      mpair_ff    <= 1'b0;
      diag_ff     <= 1'b0;
    end else begin
      fast_pos_ff <= fast_on & nxt_neg_next; // polarity fixed at launch
      fast_neg_ff <= fast_on & ~nxt_neg_next;
      lp_drive_ff <= (nxt_pulse_left != 8'h00) & ~nxt_ctrl[`CRCAP_CTRL_FAST];
      lp_full_ff  <= (nxt_pulse_left != 8'h00) & ~nxt_ctrl[`CRCAP_CTRL_FAST] &
                     (nxt_ctrl[`CRCAP_CTRL_WID_HI:`CRCAP_CTRL_WID_LO] != 3'd1);
      lpair_ff    <= nxt_ctrl[`CRCAP_CTRL_LPAIR];
      mpair_ff    <= nxt_ctrl[`CRCAP_CTRL_MPAIR];
      diag_ff     <= nxt_ctrl[`CRCAP_CTRL_ENABLE];
    end
  end

  assign prdata            = prdata_ff;
  assign pready            = pready_ff;
  assign pslverr           = pslverr_ff;
  assign diag_mode_force   = diag_ff;
  assign fast_pulse_pos    = fast_pos_ff;
  assign fast_pulse_neg    = fast_neg_ff;
  assign link_pulse_drive  = lp_drive_ff;
  assign link_pulse_full   = lp_full_ff;
  assign launch_on_rx_pair = lpair_ff;
  assign monitor_rx_pair   = mpair_ff;

endmodule

// File: sim/crcap_cable.sv
`timescale 1ns/1ns
// ****************
// Cable pair: echoes the last pulse on the monitored pair
// ****************
module crcap_cable (
  input wire       pclk,
  input wire       presetn,
  input wire       clear,
  input wire [5:0] amp,
  input wire       diag_mode_force,
  input wire       fast_pulse_pos,
  input wire       fast_pulse_neg,
  input wire       link_pulse_drive,
  input wire       launch_on_rx_pair,
  input wire       monitor_rx_pair,
  output reg [5:0] rx_sample
);
  reg [1:0] echo_ff;
  // Line out of test mode is noise, so stale levels never pass
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      echo_ff   <= 2'h0;
      rx_sample <= 6'h15;
    end else begin
      if (clear) echo_ff <= 2'h0;
      else if (fast_pulse_neg) echo_ff <= 2'h2;
      else if (fast_pulse_pos || link_pulse_drive) echo_ff <= 2'h1;
      if (!diag_mode_force) rx_sample <= ~rx_sample;
      else if (echo_ff == 2'h0 || launch_on_rx_pair != monitor_rx_pair) rx_sample <= 6'h20;
      else rx_sample <= (echo_ff == 2'h1) ? 6'h20 + amp : 6'h20 - amp;
    end
  end
endmodule

// File: sim/crcap_props.sv
`timescale 1ns/1ns
// ****************
// Bus and pulse checks
// ****************
module crcap_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        diag_mode_force,
  input wire        fast_pulse_pos,
  input wire        fast_pulse_neg,
  input wire        link_pulse_drive,
  input wire        link_pulse_full,
  input wire        launch_on_rx_pair,
  input wire        monitor_rx_pair
);
  reg  [2:0] wid_ff;
  reg  [3:0] cnt_ff;
  reg        neg_ff;
  wire       acc  = psel && penable && !pready;
  wire       cwr  = acc && pwrite && paddr[7:2] == 6'h16;
  wire       fpul = fast_pulse_pos || fast_pulse_neg;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Width taken at the commit edge, so a pulse in the next cycle sees it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wid_ff <= 3'h0;
      cnt_ff <= 4'h0;
      neg_ff <= 1'b1;
    end else begin
      if (cwr) wid_ff <= pwdata[10:8];
      cnt_ff <= (fpul || link_pulse_drive) ? cnt_ff + 4'h1 : 4'h0;
      if (fpul) neg_ff <= fast_pulse_neg;
    end
  end
  a_ready_wait: assert property (acc |=> pready)
    else $error("ready missing after access");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (pready && paddr[7:2] > 6'h19 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0 &&
    (paddr[7:2] != 6'h18 || prdata[15:14] == 2'h0)) else $error("reserved bits set");
  a_ctrl_pins: assert property (cwr |-> ##2 diag_mode_force == $past(pwdata[15], 2) &&
    launch_on_rx_pair == $past(pwdata[13], 2) && monitor_rx_pair == $past(pwdata[12], 2))
    else $error("control pins wrong");
  a_fast_width: assert property ($fell(fpul) |-> cnt_ff == {1'b0, wid_ff})
    else $error("fast pulse length wrong");
  a_link_width: assert property ($fell(link_pulse_drive) |->
    cnt_ff == ($past(link_pulse_full) ? 4'ha : 4'h5)) else $error("link pulse length wrong");
  a_link_full: assert property ($rose(link_pulse_drive) |-> link_pulse_full == (wid_ff > 3'h1))
    else $error("link pulse kind wrong");
  a_pulse_alt: assert property ($rose(fpul) |-> fast_pulse_pos == neg_ff)
    else $error("fast pulse polarity not alternating");
  a_zero_width: assert property (fpul || link_pulse_drive |-> wid_ff != 3'h0 &&
    !(fpul && link_pulse_drive)) else $error("pulse with zero width");
  a_pulse_bound: assert property (cnt_ff <= 4'ha)
    else $error("pulse runs too long");
  a_pol_steady: assert property (fpul && $past(fpul) |-> $stable(fast_pulse_neg))
    else $error("fast pulse polarity changed mid pulse");
  c_err: cover property (pslverr);
  c_neg: cover property ($rose(fast_pulse_neg));
  c_full: cover property ($fell(link_pulse_full));
endmodule

// File: sim/tb.sv
`timescale 1ns/1ns
// ****************
// Capture block bench
// ****************
module tb;
  reg          pclk, presetn, psel, penable, pwrite, clear;
  reg  [7:0]   paddr;
  reg  [31:0]  pwdata;
  reg  [5:0]   amp;
  wire [31:0]  prdata;
  wire [5:0]   rx_sample;
  wire         pready, pslverr, diag, fpos, fneg, ldrv, lfull, lrx, mrx;
  int          n_mismatch = 0;
  int          n_compared = 0;
  logic [31:0] d;
  logic        e;
  crcap_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_sample(rx_sample), .diag_mode_force(diag), .fast_pulse_pos(fpos),
    .fast_pulse_neg(fneg), .link_pulse_drive(ldrv), .link_pulse_full(lfull),
    .launch_on_rx_pair(lrx), .monitor_rx_pair(mrx));
  crcap_cable u_cable (.pclk(pclk), .presetn(presetn), .clear(clear), .amp(amp),
    .diag_mode_force(diag), .fast_pulse_pos(fpos), .fast_pulse_neg(fneg),
    .link_pulse_drive(ldrv), .launch_on_rx_pair(lrx), .monitor_rx_pair(mrx),
    .rx_sample(rx_sample));
  task automatic chk(input [31:0] got, input [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Idle cycle at the end, so strobes never change twice at one edge
  // Only the diagnostics page is decoded here, page select is outside
  task automatic apb(input bit wr, input [5:0] idx, input [15:0] wd);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= {16'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    d = prdata;
    e = pslverr;
    if (n == 40) chk(0, 1, "no ready");
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input [5:0] idx, input [31:0] exp, input string what);
    apb(1'b0, idx, 16'h0);
    chk(d, exp, what);
  endtask
  // Launch, poll the launch bit until it drops, then read both results
  task automatic run(input [15:0] c, w, pk, th);
    int n;
    n = 0;
    apb(1'b1, 6'h17, w);
    apb(1'b1, 6'h16, c | 16'h0800);
    apb(1'b0, 6'h16, 16'h0);
    if (w[7:0] >= w[15:8]) chk({31'h0, d[11]}, 1, "busy");
    while (d[11] === 1'b1 && n < 100) begin
      apb(1'b0, 6'h16, 16'h0);
      n++;
    end
    chk(d, {16'h0, c}, "ctrl");
    rdc(6'h18, {16'h0, pk}, "peak");
    rdc(6'h19, {16'h0, th}, "thr");
  endtask
  task t_regs;
    rdc(6'h16, 32'h20, "ctrl rst");
    rdc(6'h17, 32'h0, "win rst");
    apb(1'b1, 6'h18, 16'hffff);
    rdc(6'h18, 32'h0, "peak ro");
    apb(1'b1, 6'h17, 16'h1234);
    rdc(6'h17, 32'h1234, "win rw");
    apb(1'b0, 6'h1f, 16'h0);
    chk({d[31:1], e}, 32'h1, "unmapped");
    apb(1'b1, 6'h16, 16'hb020);
    chk({29'h0, diag, lrx, mrx}, 32'h7, "pins");
    apb(1'b1, 6'h16, 16'h4020);
    chk({29'h0, diag, lrx, mrx}, 32'h0, "pins off");
  endtask
  task t_base;
    clear <= 1'b1;
    run(16'h8020, 16'h0814, 16'h2008, 16'h0);
  endtask
  task t_fast;
    clear <= 1'b0;
    run(16'hc328, 16'h0a14, 16'h300a, 16'h010a);
    run(16'hc3a8, 16'h0a14, 16'h100a, 16'h010a);
    run(16'he728, 16'h0a14, 16'h200a, 16'h0);
    run(16'hc728, 16'h0002, 16'h2000, 16'h0);
  endtask
  task t_link;
    run(16'h8128, 16'h0a14, 16'h300a, 16'h010a);
    run(16'h9528, 16'h0a14, 16'h200a, 16'h0);
    run(16'h8328, 16'h1404, 16'h0, 16'h0);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, clear} = 5'h1;
    paddr  = 8'h0;
    pwdata = 32'h0;
    amp    = 6'h10;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_base;
    t_fast;
    t_link;
    final_report;
  end
  // Hang guard, well past the few hundred cycles needed
  initial begin
    #200000;
    n_mismatch++;
    final_report;
  end
endmodule
bind crcap_top crcap_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .diag_mode_force(diag_mode_force),
  .fast_pulse_pos(fast_pulse_pos), .fast_pulse_neg(fast_pulse_neg),
  .link_pulse_drive(link_pulse_drive), .link_pulse_full(link_pulse_full),
  .launch_on_rx_pair(launch_on_rx_pair), .monitor_rx_pair(monitor_rx_pair));
